// File: design/cam_trig_cfg.svh
// Purpose: Constants for the trigger and acquisition timing controller
// Assumes: 50 MHz system clock
// Notes:   Offsets are word indices on the plain register port
`ifndef CAM_TRIG_CFG_SVH
`define CAM_TRIG_CFG_SVH

// ***********************************
// Register offsets
// ***********************************
`define OFS_KIND_SELECT   8'h00
`define OFS_TRIG_CTRL     8'h01
`define OFS_TRIG_HOLD_OFF 8'h02
`define OFS_SOFT_TRIG     8'h03
`define OFS_EXPOSURE      8'h04
`define OFS_EXPO_CTRL     8'h05
`define OFS_REQ_RATE      8'h06
`define OFS_ACH_RATE      8'h07
`define OFS_ROW_RATE      8'h08
`define OFS_SESSION       8'h09
`define OFS_FRAME_COUNT   8'h0a
`define OFS_STATUS        8'h0b

// ***********************************
// Field positions
// ***********************************
`define TC_ARM_BIT        0
`define TC_QUAL_LSB       1
`define TC_POL_LSB        4
`define TC_ORIGIN_LSB     8
`define EC_STYLE_BIT      0
`define EC_AUTO_LSB       1
`define EC_GATE_BIT       3
`define EC_CNT_LSB        4
`define EC_SHUT_BIT       6
`define SS_BEGIN_BIT      0
`define SS_END_BIT        1

// ***********************************
// Reset values and timing
// ***********************************
`define RST_EXPOSURE      32'h00002710
`define RST_REQ_RATE      32'h0000001e
`define RST_ROW_RATE      32'h00007530
`define RST_FRAME_COUNT   32'h00000001
`define CLK_MHZ           32'h00000032
`define CLK_HZ            32'h02faf080

`endif

// File: design/cam_trig_ctrl.sv
// Purpose: Trigger and acquisition timing controller of the camera
// Assumes: One 50 MHz clock, host on a plain register port
// Notes:   Rates are whole hertz, times whole microseconds
// Function
// [R1] Kind selector picks which of three triggers the per-trigger registers reach
// [R2] Each trigger kind has an arm bit; only armed triggers gate events
// [R3] Soft trigger write pulses the selected kind if its origin is software
// [R4] Origin chosen from software, pins, user outputs, counters, logic, action
// [R5] Origin qualified by low, high, falling, rising or either transition
// [R6] Each kind holds an overlap policy: none, overlap_with_a or prior image
// [R7] Qualified trigger waits a programmed microsecond hold-off before acting
// [R8] Timed style exposes each frame for the programmed microseconds
// [R9] Auto exposure setting holds off, once or continuous
// [R10] Host writes a requested frame rate in hertz
// [R11] Requested rate paces frames only while the manual rate gate is set
// [R12] Achieved rate reported, lower when exposure exceeds frame period
// [R13] Row capture rate in hertz sets row pacing
// [R14] Shutter style holds only global shutter
// [R15] Exposure style is timed or pulse width of the trigger
// [R16] Capture count style continuous, multi-frame or single-frame
// [R17] Host issues begin and end commands for a session
// [R18] External pins pass a two-flop synchroniser before qualification
// [R19] Under no overlap, triggers while busy are ignored until overlap_with_a ends
`timescale 1ns/1ps
`include "cam_trig_cfg.svh"
module cam_trig_ctrl
   import cam_trig_pkg::*;
#(
   parameter int OVERLAP_WITH_A_ROWS = 1080
)(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Trigger origins
   input  wire logic [3:0]  input_pin,
   input  wire logic [3:0]  user_out,
   input  wire logic [3:0]  count_event,
   input  wire logic [1:0]  logic_unit_out,
   input  wire logic        network_action_a,
   // Sensor timing
   output logic             expose_active,
   output logic             overlap_with_a_active,
   output logic             row_strobe,
   output logic             frame_done
);
   typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_EXPOSE, ST_READ} state_type;

   // ***********************************
   // Registers and synchroniser
   // ***********************************
   logic [1:0]  kind_sel, next_kind_sel;
   logic [11:0] tctrl [3], next_tctrl [3];
   logic [31:0] hold_off [3], next_hold_off [3];
   logic [31:0] exposure, next_exposure;
   logic [6:0]  ectrl, next_ectrl;
   logic [31:0] req_rate, next_req_rate;
   logic [31:0] row_rate, next_row_rate;
   logic [31:0] frame_count, next_frame_count;
   logic [31:0] ach_rate, next_ach_rate;
   logic        soft_pulse, next_soft_pulse;
   logic        session, next_session;
   logic        once_busy, next_once_busy;
   logic [3:0]  pin_meta, pin_sync;
   logic [31:0] next_rdata;
   state_type   state, next_state;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
      end else begin
         pin_meta <= input_pin;  // R18
         pin_sync <= pin_meta;   // R18
      end
   end

   logic [15:0] origins;
   // R4
   assign origins = {network_action_a, logic_unit_out, count_event[3], count_event[1],
                     count_event[2], count_event[0], user_out, pin_sync, soft_pulse};

   logic [2:0] hit, lvl;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_q
         trig_qualify u_q (
            .clk_sys    (clk_sys),
            .rstn       (rstn),
            .origins    (origins),
            .origin_sel (tctrl[g][`TC_ORIGIN_LSB +: 4]),
            .qualify    (tctrl[g][`TC_QUAL_LSB +: 3]),  // R5
            .hit        (hit[g]),
            .level      (lvl[g])
         );
      end
   endgenerate

   // ***********************************
   // Register write and read
   // ***********************************
   logic sel_soft;
   assign sel_soft = tctrl[kind_sel][`TC_ORIGIN_LSB +: 4] == 4'h0;

   always_comb begin
      next_kind_sel    = kind_sel;
      next_tctrl       = tctrl;
      next_hold_off    = hold_off;
      next_exposure    = exposure;
      next_ectrl       = ectrl;
      next_req_rate    = req_rate;
      next_row_rate    = row_rate;
      next_frame_count = frame_count;
      next_soft_pulse  = 1'b0;
      next_rdata       = 32'h0;
      if (reg_wr) begin
         case (reg_addr)
            `OFS_KIND_SELECT:   next_kind_sel = reg_wdata[1:0];  // R1
            `OFS_TRIG_CTRL:     next_tctrl[kind_sel] = reg_wdata[11:0];  // R2 R6
            `OFS_TRIG_HOLD_OFF: next_hold_off[kind_sel] = reg_wdata;  // R7
            `OFS_SOFT_TRIG:     next_soft_pulse = reg_wdata[0] & sel_soft;  // R3
            `OFS_EXPOSURE:      next_exposure = reg_wdata;  // R8
            `OFS_EXPO_CTRL:     next_ectrl = {1'b0, reg_wdata[5:0]};  // R9 R14
            `OFS_REQ_RATE:      next_req_rate = reg_wdata;  // R10
            `OFS_ROW_RATE:      next_row_rate = reg_wdata;  // R13
            `OFS_FRAME_COUNT:   next_frame_count = reg_wdata;
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `OFS_KIND_SELECT:   next_rdata = {30'h0, kind_sel};
            `OFS_TRIG_CTRL:     next_rdata = {20'h0, tctrl[kind_sel]};
            `OFS_TRIG_HOLD_OFF: next_rdata = hold_off[kind_sel];
            `OFS_EXPOSURE:      next_rdata = exposure;
            `OFS_EXPO_CTRL:     next_rdata = {25'h0, ectrl};
            `OFS_REQ_RATE:      next_rdata = req_rate;
            `OFS_ACH_RATE:      next_rdata = ach_rate;  // R12
            `OFS_ROW_RATE:      next_rdata = row_rate;
            `OFS_FRAME_COUNT:   next_rdata = frame_count;
            `OFS_STATUS:        next_rdata = {28'h0, expose_active, overlap_with_a_active,
                                              once_busy, session};
            default:            next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         kind_sel    <= 2'h0;
         for (int i = 0; i < 3; i++) begin
            tctrl[i]    <= 12'h0;
            hold_off[i] <= 32'h0;
         end
         exposure    <= `RST_EXPOSURE;
         ectrl       <= 7'h0;
         req_rate    <= `RST_REQ_RATE;
         row_rate    <= `RST_ROW_RATE;
         frame_count <= `RST_FRAME_COUNT;
         soft_pulse  <= 1'b0;
         reg_rdata   <= 32'h0;
      end else begin
         kind_sel    <= next_kind_sel;
         tctrl       <= next_tctrl;
         hold_off    <= next_hold_off;
         exposure    <= next_exposure;
         ectrl       <= next_ectrl;
         req_rate    <= next_req_rate;
         row_rate    <= next_row_rate;
         frame_count <= next_frame_count;
         soft_pulse  <= next_soft_pulse;
         reg_rdata   <= next_rdata;
      end
   end

   // ***********************************
   // Microsecond and row tick dividers
   // ***********************************
   logic [5:0]  us_cnt;
   logic        us_tick;
   logic [31:0] row_cnt, row_period;
   assign us_tick    = us_cnt == 6'(`CLK_MHZ - 1);
   assign row_period = (row_rate == 32'h0) ? 32'h1 : `CLK_HZ / row_rate;  // R13

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         us_cnt  <= 6'h0;
         row_cnt <= 32'h0;
      end else begin
         us_cnt  <= (us_tick || next_state != state) ? 6'h0 : us_cnt + 6'h1;
         row_cnt <= (row_cnt + 32'h1 >= row_period) ? 32'h0 : row_cnt + 32'h1;
      end
   end

   // ***********************************
   // Session and frame sequencer
   // ***********************************
   logic [31:0] timer, next_timer;
   logic [31:0] done_cnt, next_done_cnt;
   logic [31:0] rows, next_rows;
   logic [31:0] pace, next_pace;
   logic [31:0] meas, next_meas;
   logic        armed_go, sess_ok;
   logic        pulse_style, gate;
   logic [1:0]  cstyle;
   logic [31:0] pace_cycles;

   assign pulse_style = ectrl[`EC_STYLE_BIT];  // R15
   assign gate        = ectrl[`EC_GATE_BIT];
   assign cstyle      = ectrl[`EC_CNT_LSB +: 2];
   assign pace_cycles = (req_rate == 32'h0) ? 32'h0 : `CLK_HZ / req_rate;
   assign sess_ok     = ~tctrl[KIND_SESSION][`TC_ARM_BIT] | hit[KIND_SESSION];  // R2
   // R2 R19
   assign armed_go    = session & sess_ok &
                        (tctrl[KIND_IMAGE][`TC_ARM_BIT] ? hit[KIND_IMAGE] :
                         (~gate | pace == 32'h0));

   always_comb begin
      next_state    = state;
      next_timer    = timer;
      next_done_cnt = done_cnt;
      next_rows     = rows;
      next_session  = session;
      next_once_busy = once_busy;
      next_pace     = (pace != 32'h0) ? pace - 32'h1 : 32'h0;
      next_meas     = meas + 32'h1;
      next_ach_rate = ach_rate;
      frame_done    = 1'b0;
      case (state)
         ST_IDLE: begin
            if (armed_go) begin  // R19
               next_timer = hold_off[KIND_IMAGE];
               next_state = ST_HOLD;
               if (gate) begin
                  next_pace = (pace_cycles == 32'h0) ? 32'h0 : pace_cycles - 32'h1;  // R11
               end
            end
         end
         ST_HOLD: begin
            if (timer == 32'h0) begin
               next_timer = exposure;
               next_state = ST_EXPOSE;
            end else if (us_tick) begin
               next_timer = timer - 32'h1;  // R7
            end
         end
         ST_EXPOSE: begin
            if (pulse_style ? ~lvl[KIND_IMAGE] : timer == 32'h0) begin  // R8 R15
               next_rows  = 32'h0;
               next_state = ST_READ;
            end else if (us_tick && timer != 32'h0) begin
               next_timer = timer - 32'h1;
            end
         end
         ST_READ: begin
            if (row_strobe) begin
               next_rows = rows + 32'h1;
            end
            if (rows >= OVERLAP_WITH_A_ROWS) begin
               frame_done     = 1'b1;
               next_once_busy = 1'b0;
               next_done_cnt  = done_cnt + 32'h1;
               next_meas      = 32'h0;
               next_ach_rate  = (meas == 32'h0) ? 32'h0 : `CLK_HZ / (meas + 32'h1);  // R12
               next_state     = ST_IDLE;
               // R16
               if (cstyle == 2'(CNT_SINGLE) ||
                   (cstyle == 2'(CNT_MULTI) && done_cnt + 32'h1 >= frame_count)) begin
                  next_session = 1'b0;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // Host set wins over a frame end in the same cycle
      if (reg_wr && reg_addr == `OFS_EXPO_CTRL && reg_wdata[2:1] == 2'(AUTO_ONCE)) begin
         next_once_busy = 1'b1;  // R9
      end
      if (reg_wr && reg_addr == `OFS_SESSION && reg_wdata[`SS_BEGIN_BIT]) begin
         next_session  = 1'b1;  // R17
         next_done_cnt = 32'h0;
      end
      if (reg_wr && reg_addr == `OFS_SESSION && reg_wdata[`SS_END_BIT]) begin
         next_session = 1'b0;  // R17
      end
   end

   assign expose_active  = state == ST_EXPOSE;  // R14
   assign overlap_with_a_active = state == ST_READ;
   assign row_strobe     = overlap_with_a_active & (row_cnt == 32'h0);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state     <= ST_IDLE;
         timer     <= 32'h0;
         done_cnt  <= 32'h0;
         rows      <= 32'h0;
         session   <= 1'b0;
         once_busy <= 1'b0;
         pace      <= 32'h0;
         meas      <= 32'h0;
         ach_rate  <= 32'h0;
      end else begin
         state     <= next_state;
         timer     <= next_timer;
         done_cnt  <= next_done_cnt;
         rows      <= next_rows;
         session   <= next_session;
         once_busy <= next_once_busy;
         pace      <= next_pace;
         meas      <= next_meas;
         ach_rate  <= next_ach_rate;
      end
   end

   // ***********************************
   // Checks
   // ***********************************
   AST_SOFT_PULSE: assert property (@(posedge clk_sys) disable iff (!rstn)  // R3
      reg_wr && reg_addr == `OFS_SOFT_TRIG && reg_wdata[0] && sel_soft |=> soft_pulse)
      else $error("soft trigger lost");
   AST_NO_SOFT: assert property (@(posedge clk_sys) disable iff (!rstn)  // R3
      reg_wr && reg_addr == `OFS_SOFT_TRIG && !sel_soft |=> !soft_pulse)
      else $error("soft trigger not gated");
   AST_HOLD_ENTRY: assert property (@(posedge clk_sys) disable iff (!rstn)  // R7
      state == ST_IDLE && armed_go |=> state == ST_HOLD && timer == $past(hold_off[KIND_IMAGE]))
      else $error("hold-off not loaded");
   AST_BUSY_IGNORE: assert property (@(posedge clk_sys) disable iff (!rstn)  // R19
      state == ST_EXPOSE |=> state inside {ST_EXPOSE, ST_READ})
      else $error("trigger accepted while busy");
   AST_END_STOPS: assert property (@(posedge clk_sys) disable iff (!rstn)  // R17
      reg_wr && reg_addr == `OFS_SESSION && reg_wdata[`SS_END_BIT] |=> !session)
      else $error("end did not stop session");
   AST_SINGLE: assert property (@(posedge clk_sys) disable iff (!rstn)  // R16
      frame_done && cstyle == 2'(CNT_SINGLE) && !reg_wr |=> !session)
      else $error("single frame did not stop");
   AST_ARM_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)  // R2
      state == ST_IDLE && !session |=> state == ST_IDLE)
      else $error("frame without session");
   AST_EXPO_TIMED: assert property (@(posedge clk_sys) disable iff (!rstn)  // R8
      state == ST_EXPOSE && !pulse_style && timer == 32'h0 |=> state == ST_READ)
      else $error("timed exposure overran");
   AST_SYNC: assert property (@(posedge clk_sys) disable iff (!rstn)  // R18
      ##2 pin_sync == $past(input_pin, 2))
      else $error("pin sync depth wrong");
endmodule

// File: design/cam_trig_pkg.sv
// Purpose: Types for the trigger and acquisition timing controller
// Assumes: Nothing
// Notes:   Enumerations follow the register encodings
package cam_trig_pkg;
   typedef enum logic [1:0] {KIND_SESSION, KIND_IMAGE, KIND_BURST} kind_type;
   typedef enum logic [2:0] {QUAL_LOW, QUAL_HIGH, QUAL_FALL, QUAL_RISE, QUAL_ANY} qual_type;
   typedef enum logic [1:0] {POL_NONE, POL_OVERLAP_WITH_A, POL_PRIOR} policy_type;
   typedef enum logic [1:0] {CNT_CONT, CNT_MULTI, CNT_SINGLE} count_style_type;
   typedef enum logic [1:0] {AUTO_OFF, AUTO_ONCE, AUTO_CONT} auto_type;
endpackage

// File: design/trig_qualify.sv
// Purpose: Selects and qualifies one trigger origin
// Assumes: Origin vector already synchronised
// Notes:   Level modes pulse once per cycle while active
`timescale 1ns/1ps
module trig_qualify
   import cam_trig_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Selection
   input  wire logic [15:0] origins,
   input  wire logic [3:0]  origin_sel,
   input  wire logic [2:0]  qualify,
   // Result
   output logic             hit,
   output logic             level
);
   logic prev;
   logic cur;
   logic next_prev;

   always_comb begin
      cur       = origins[origin_sel];
      next_prev = cur;
      case (qualify)
         QUAL_LOW:  hit = ~cur;
         QUAL_HIGH: hit = cur;
         QUAL_FALL: hit = prev & ~cur;
         QUAL_RISE: hit = ~prev & cur;
         QUAL_ANY:  hit = prev ^ cur;
         default:   hit = 1'b0;
      endcase
      level = (qualify == QUAL_LOW) ? ~cur : cur;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end
endmodule

// File: tb/cam_trig_ctrl_test.sv
// Purpose: Self-checking bench of the trigger and timing controller
// Assumes: 50 MHz clock, overlap_with_a shortened to four rows
// Notes:   Row rate raised so that one row is one microsecond
`timescale 1ns/1ps
`include "cam_trig_cfg.svh"
module cam_trig_ctrl_test
   import cam_trig_pkg::*;
;
   localparam int ROWS = 4;
   localparam int US   = 50;
   logic        clk_sys;
   logic        rstn;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [3:0]  input_pin;
   logic [3:0]  user_out;
   logic [3:0]  count_event;
   logic [1:0]  logic_unit_out;
   logic        network_action_a;
   logic        expose_active;
   logic        overlap_with_a_active;
   logic        row_strobe;
   logic        frame_done;
   int          bad_count;
   int          comparisons;
   logic [31:0] seed;
   logic [31:0] got;
   logic [31:0] v;
   int          lat;
   int          elen;
   int          rows;
   bit          done;
   logic [7:0]  ra [8] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h05, 8'h03, 8'h3f, 8'h00};
   logic [31:0] rv [8] = '{32'h2710, 32'h1e, 32'h7530, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

   // ***********************************
   // Design and far side
   // ***********************************
   cam_trig_ctrl #(.OVERLAP_WITH_A_ROWS(ROWS)) uut (
      .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_pin(input_pin),
      .user_out(user_out), .count_event(count_event), .logic_unit_out(logic_unit_out),
      .network_action_a(network_action_a), .expose_active(expose_active),
      .overlap_with_a_active(overlap_with_a_active), .row_strobe(row_strobe), .frame_done(frame_done));
   trig_line_model src (
      .clk_sys(clk_sys), .input_pin(input_pin), .user_out(user_out),
      .count_event(count_event), .logic_unit_out(logic_unit_out),
      .network_action_a(network_action_a));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // ***********************************
   // Helpers
   // ***********************************
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] ctl(input bit arm, input int q, input int p, input int o);
      return (arm << `TC_ARM_BIT) | (q << `TC_QUAL_LSB) | (p << `TC_POL_LSB)
         | (o << `TC_ORIGIN_LSB);
   endfunction
   // Model: does a move from level s to the other level fire
   function automatic bit fires(input int q, input bit s);
      case (q)
         QUAL_LOW, QUAL_FALL: return s;
         QUAL_HIGH, QUAL_RISE: return !s;
         default: return 1'b1;
      endcase
   endfunction
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // Watches one frame; a required frame that never ends stops the run
   task automatic measure(input int lim, input bit must);
      lat  = -1;
      elen = 0;
      rows = 0;
      done = 0;
      for (int i = 0; i < lim && !done; i++) begin
         @(posedge clk_sys);
         #1;
         if (expose_active === 1'b1 && lat < 0) lat = i;
         if (expose_active === 1'b1) elen++;
         if (row_strobe === 1'b1) rows++;
         if (frame_done === 1'b1) done = 1;
      end
      if (must && !done) begin
         bad_count++;
         $display("[ERR] %0t frame never ended", $time);
         test_done();
      end
   endtask
   // Hold-off is invisible at the ports, so demand a long quiet spell
   task automatic idle_wait();
      int quiet;
      quiet = 0;
      for (int i = 0; i < 4000 && quiet < 150; i++) begin
         @(posedge clk_sys);
         #1;
         quiet = (expose_active === 1'b0 && overlap_with_a_active === 1'b0) ? quiet + 1 : 0;
      end
      if (quiet < 150) begin
         bad_count++;
         $display("[ERR] %0t never idle", $time);
         test_done();
      end
   endtask

   // ***********************************
   // Main sequence
   // ***********************************
   initial begin
      rstn      = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      seed      = 32'h2d75;
      bad_count = 0;
      comparisons = 0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(ra[i], got);
         check(got, rv[i], "reset value");
      end
      $display("test reset values done");
      for (int k = 0; k < 3; k++) begin
         wr(`OFS_KIND_SELECT, k);
         wr(`OFS_TRIG_CTRL, ctl(k[0], k, k, k));
      end
      for (int k = 0; k < 3; k++) begin
         wr(`OFS_KIND_SELECT, k);
         rd(`OFS_TRIG_CTRL, got);
         check(got, ctl(k[0], k, k, k), "per kind ctrl");
      end
      v = xorshift() & 32'hffff;
      wr(`OFS_EXPOSURE, v);
      rd(`OFS_EXPOSURE, got);
      check(got, v, "exposure");
      v = xorshift() & 32'hfffff;
      wr(`OFS_ROW_RATE, v);
      rd(`OFS_ROW_RATE, got);
      check(got, v, "row rate");
      for (int a = 0; a < 3; a++) begin
         for (int c = 0; c < 3; c++) begin
            v = a[0] | (a << `EC_AUTO_LSB) | (c[0] << `EC_GATE_BIT) | (c << `EC_CNT_LSB) | 32'h40;
            wr(`OFS_EXPO_CTRL, v);
            rd(`OFS_EXPO_CTRL, got);
            check(got, v & 32'h3f, "expo ctrl");
         end
      end
      $display("test register storage done");
      wr(`OFS_EXPO_CTRL, 32'h0);
      wr(`OFS_EXPOSURE, 32'h4);
      wr(`OFS_ROW_RATE, 32'h000f4240);
      wr(`OFS_KIND_SELECT, KIND_SESSION);
      wr(`OFS_TRIG_CTRL, ctl(0, QUAL_RISE, 0, 1));
      wr(`OFS_KIND_SELECT, KIND_IMAGE);
      wr(`OFS_TRIG_HOLD_OFF, 32'h2);
      wr(`OFS_TRIG_CTRL, ctl(1, QUAL_RISE, POL_NONE, 0));
      wr(`OFS_SESSION, 32'h1);
      rd(`OFS_STATUS, got);
      check(got & 32'h1, 32'h1, "session open");
      fork
         measure(3000, 1);
         begin
            wr(`OFS_SOFT_TRIG, 32'h1);
            repeat (150) @(posedge clk_sys);
            wr(`OFS_SOFT_TRIG, 32'h1);
         end
      join
      check(lat >= 2 * US - 4 && lat <= 2 * US + 8, 1, "hold-off");
      check(elen >= 4 * US - 1 && elen <= 4 * US + 1, 1, "exposure length");
      check(rows, ROWS, "rows");
      measure(800, 0);
      check(done, 0, "busy trigger ignored");
      $display("test soft frame done");
      wr(`OFS_TRIG_CTRL, ctl(1, QUAL_RISE, POL_NONE, 1));
      wr(`OFS_SOFT_TRIG, 32'h1);
      measure(800, 0);
      check(done, 0, "soft with pin origin");
      $display("test soft refused done");
      for (int q = 0; q < 5; q++) begin
         for (int s = 0; s < 2; s++) begin
            if (q > QUAL_HIGH || fires(q, s)) begin
               wr(`OFS_TRIG_CTRL, ctl(1, QUAL_RISE, POL_NONE, 2));
               src.set_pin(0, s[0]);
               src.set_pin(1, s[0]);
               idle_wait();
               wr(`OFS_TRIG_CTRL, ctl(1, q, POL_NONE, 1));
               repeat (10) @(posedge clk_sys);
               src.set_pin(0, !s[0]);
               measure(1500, 0);
               check(done, fires(q, s), "pin qualify");
               wr(`OFS_TRIG_CTRL, ctl(1, QUAL_RISE, POL_NONE, 2));
               idle_wait();
            end
         end
      end
      $display("test pin qualify done");
      wr(`OFS_TRIG_CTRL, ctl(1, QUAL_RISE, POL_NONE, 0));
      wr(`OFS_SESSION, 32'h2);
      rd(`OFS_STATUS, got);
      check(got & 32'h1, 32'h0, "session closed");
      wr(`OFS_SOFT_TRIG, 32'h1);
      measure(800, 0);
      check(done, 0, "closed session");
      wr(`OFS_EXPO_CTRL, CNT_SINGLE << `EC_CNT_LSB);
      wr(`OFS_SESSION, 32'h1);
      wr(`OFS_SOFT_TRIG, 32'h1);
      measure(3000, 1);
      idle_wait();
      wr(`OFS_SOFT_TRIG, 32'h1);
      measure(800, 0);
      check(done, 0, "single frame stop");
      $display("test session done");
      wr(`OFS_EXPO_CTRL, 32'h1);
      wr(`OFS_TRIG_CTRL, ctl(1, QUAL_HIGH, POL_NONE, 1));
      wr(`OFS_SESSION, 32'h1);
      fork
         measure(2000, 1);
         begin
            src.set_pin(0, 1'b1);
            repeat (300) @(posedge clk_sys);
            src.set_pin(0, 1'b0);
         end
      join
      check(elen >= 4 * US - 2 && elen <= 4 * US + 2, 1, "pulse width exposure");
      $display("test pulse width done");
      wr(`OFS_REQ_RATE, 32'd10000);
      wr(`OFS_FRAME_COUNT, 32'h3);
      wr(`OFS_EXPO_CTRL, 32'h8 | (CNT_MULTI << `EC_CNT_LSB));
      wr(`OFS_TRIG_CTRL, ctl(0, QUAL_RISE, POL_NONE, 0));
      wr(`OFS_SESSION, 32'h1);
      repeat (3) measure(6000, 1);
      measure(6000, 0);
      check(done, 0, "multi frame stop");
      rd(`OFS_ACH_RATE, got);
      check(got, 32'd10000, "achieved rate");
      wr(`OFS_EXPOSURE, 32'd150);
      wr(`OFS_SESSION, 32'h1);
      repeat (3) measure(9000, 1);
      rd(`OFS_ACH_RATE, got);
      check(got < 32'd10000 && got > 32'h0, 1, "achieved slower");
      $display("test frame rate done");
      test_done();
   end
endmodule

// File: tb/trig_line_model.sv
// Purpose: Far-side model of trigger lines and same-clock origins
// Assumes: Pins are asynchronous to clk_sys
// Notes:   Pins move mid-cycle to exercise the synchroniser
`timescale 1ns/1ps
module trig_line_model (
   // Clock
   input  wire logic       clk_sys,
   // Origins
   output logic      [3:0] input_pin,
   output logic      [3:0] user_out,
   output logic      [3:0] count_event,
   output logic      [1:0] logic_unit_out,
   output logic            network_action_a
);
   initial begin
      input_pin        = 4'h0;
      user_out         = 4'h0;
      count_event      = 4'h0;
      logic_unit_out   = 2'h0;
      network_action_a = 1'b0;
   end
   // Off-edge on purpose: a real line has no phase relation to the clock
   task automatic set_pin(input int idx, input logic v);
      @(posedge clk_sys);
      #7;
      input_pin[idx] = v;
   endtask
endmodule
